// *** rtl/niciu_pkg.sv ***
// Package: register map, status bit positions and command field layouts
package niciu_pkg;

  // ----------------------------------------
  // Register offsets (printed offsets are not all multiples of four: index form)
  // ----------------------------------------
  localparam logic [7:0] NICIU_IDX_INTERRUPT_MASK = 8'h5a;
  localparam logic [7:0] NICIU_IDX_INDICATION_MASK = 8'h5c;
  localparam logic [7:0] NICIU_IDX_EVENT_STATUS = 8'h5e;
  localparam logic [7:0] NICIU_IDX_COMMAND = 8'h60;
  localparam logic [9:0] NICIU_ADDR_INTERRUPT_MASK = {NICIU_IDX_INTERRUPT_MASK, 2'b00};
  localparam logic [9:0] NICIU_ADDR_INDICATION_MASK = {NICIU_IDX_INDICATION_MASK, 2'b00};
  localparam logic [9:0] NICIU_ADDR_EVENT_STATUS = {NICIU_IDX_EVENT_STATUS, 2'b00};
  localparam logic [9:0] NICIU_ADDR_COMMAND = {NICIU_IDX_COMMAND, 2'b00};

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int NICIU_B_SUMMARY = 0;
  localparam int NICIU_B_HOST_FAULT = 1;
  localparam int NICIU_B_TX_DONE = 2;
  localparam int NICIU_B_UPD_WANTED = 3;
  localparam int NICIU_B_RX_DONE = 4;
  localparam int NICIU_B_REQ_IRQ = 6;
  localparam int NICIU_B_MEDIA_FAULT = 7;
  localparam int NICIU_B_DN_DONE = 9;
  localparam int NICIU_B_UP_DONE = 10;
  localparam int NICIU_B_TX_STARVE = 11;
  localparam int NICIU_B_CMD_PEND = 12;
  localparam int NICIU_B_ASTAT_FREE = 13;
  localparam int NICIU_B_SYS_REQ = 14;
  localparam int NICIU_B_AREQ = 15;

  // Bits that may hold a value; reserved 5 and 8 excluded
  localparam logic [15:0] NICIU_LIVE_BITS = 16'hfedf;
  // Interrupt-capable bits; summary and command-pending excluded
  localparam logic [15:0] NICIU_IRQ_BITS = 16'heede;
  // Acknowledge bits; those above bit 10 lie beyond the 11-bit argument and never clear
  localparam logic [15:0] NICIU_ACK_BITS = 16'he645;
  localparam logic [15:0] NICIU_RESET_VAL = 16'h0000;

  // Media controller status bits that raise the media fault
  localparam logic [15:0] NICIU_MEDIA_FAULT_SEL = 16'h400c;

  // ----------------------------------------
  // Command word layout
  // ----------------------------------------
  localparam int NICIU_CMD_OP_HI = 15;
  localparam int NICIU_CMD_OP_LO = 11;
  localparam int NICIU_CMD_ARG_HI = 10;
  localparam int NICIU_CMD_ARG_LO = 0;
  localparam int NICIU_FULL_RESET_B8 = 8;
  localparam int NICIU_FULL_RESET_B5 = 5;
  localparam int NICIU_FULL_RESET_B3 = 3;

  typedef enum logic [4:0] {
    NICIU_OP_FULL_RESET = 5'h00,
    NICIU_OP_DOWNLOAD_RESET = 5'h0a,
    NICIU_OP_ACKNOWLEDGE = 5'h0d,
    NICIU_OP_SOFTWARE_IRQ = 5'h0c,
    NICIU_OP_LOAD_INDICATION = 5'h0f,
    NICIU_OP_LOAD_INTERRUPT = 5'h0e,
    NICIU_OP_RECEIVE_DROP = 5'h08
  } niciu_op_e;

  // Event pulses from the adapter sources
  typedef struct packed {
    logic target_abort;
    logic master_abort;
    logic false_starve;
    logic transmit_done;
    logic upload_descriptor_wanted;
    logic receive_pending;
    logic countdown_expired;
    logic download_done;
    logic upload_done;
    logic transmit_starve;
    logic command_pending;
    logic adapter_status_free;
    logic system_request;
    logic adapter_request;
  } niciu_events_s;

  // Register port request
  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } niciu_req_s;

endpackage

// *** rtl/niciu_top.sv ***
// Indication and interrupt unit: status, masks, summary latch and PCI interrupt line
//
// Summary of operation
// - A status bit other than summary bit 0 reads as one only while its indication mask bit is one; edge bits also set only then.
// - Interrupt line is set by OR of status bits gated by interrupt mask bits; it holds until summary acknowledge.
// - Summary bit 0 sets with the interrupt pin; cleared only by summary acknowledge.
// - Mask changes act at once; masked events read zero, stay pending inside.
// - Enabling an already pending event raises the interrupt at once.
// - Summary bit is always enabled regardless of both masks.
// - Masking never clears a pending event; it reappears when unmasked.
// - Command-pending bit never reads as one, since indication mask bit 12 always loads zero, and never interrupts.
// - One acknowledge can clear a source bit and the summary bit together.
// - Download reset clears transmit starve only; summary bit untouched.
// - Masks clear on reset or host reset; loaded only by their commands.
// - Host fault bit 1 sets on aborts or false starve; cleared by full reset with argument bits 8, 5 and 3 zero.
// - Transmit done bit 2 sets on flagged frame end; cleared by acknowledge.
// - Bit 3 follows the descriptor-wanted condition; cleared by descriptor or drop.
// - Receive done bit 4 stays set while complete packets remain.
// - Bit 6 sets on countdown or software request; cleared by acknowledge.
// - Bit 7 sets on media status bits 14, 3 or 2; cleared only by full reset.
// - Download and upload bits clear by their own acknowledge bit; the three block bits 13-15 never clear.
// - Download done is bit 9, upload done is bit 10.
`timescale 1ns/1ns
module niciu_top
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic host_side_reset_bit_i,
  // Register port
  input wire logic [9:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Event sources
  input wire niciu_pkg::niciu_events_s events_i,
  input wire logic [15:0] media_ctrl_status_i,
  // Interrupt line
  output logic pci_irq_o
);
  import niciu_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] pending;
  logic [15:0] indication_mask;
  logic [15:0] interrupt_mask;
  logic summary;
  logic [15:0] next_pending;
  logic next_summary;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  wire cmd_wr = reg_wr_i && (reg_addr_i == NICIU_ADDR_COMMAND);
  wire [4:0] cmd_op = reg_wdata_i[NICIU_CMD_OP_HI:NICIU_CMD_OP_LO];
  wire [10:0] cmd_arg = reg_wdata_i[NICIU_CMD_ARG_HI:NICIU_CMD_ARG_LO];
  wire is_ack = cmd_wr && (cmd_op == NICIU_OP_ACKNOWLEDGE);
  wire is_dn_reset = cmd_wr && (cmd_op == NICIU_OP_DOWNLOAD_RESET);
  wire is_drop = cmd_wr && (cmd_op == NICIU_OP_RECEIVE_DROP);
  wire is_swirq = cmd_wr && (cmd_op == NICIU_OP_SOFTWARE_IRQ);
  wire is_ld_ind = cmd_wr && (cmd_op == NICIU_OP_LOAD_INDICATION);
  wire is_ld_int = cmd_wr && (cmd_op == NICIU_OP_LOAD_INTERRUPT);
  wire is_full_reset = cmd_wr && (cmd_op == NICIU_OP_FULL_RESET);
  wire fault_clear = is_full_reset && !cmd_arg[NICIU_FULL_RESET_B8]
    && !cmd_arg[NICIU_FULL_RESET_B5] && !cmd_arg[NICIU_FULL_RESET_B3];
  // Acknowledge argument holds the ack bits at status bit positions
  wire [15:0] ack_mask = is_ack ? ({5'h00, cmd_arg} & NICIU_ACK_BITS) : 16'h0000;

  // ----------------------------------------
  // Event set and clear vectors
  // ----------------------------------------
  wire [15:0] set_vec;
  assign set_vec[NICIU_B_SUMMARY] = 1'b0;
  assign set_vec[NICIU_B_HOST_FAULT] = events_i.target_abort | events_i.master_abort
    | events_i.false_starve;
  assign set_vec[NICIU_B_TX_DONE] = events_i.transmit_done;
  assign set_vec[NICIU_B_UPD_WANTED] = 1'b0;
  assign set_vec[NICIU_B_RX_DONE] = 1'b0;
  assign set_vec[5] = 1'b0;
  assign set_vec[NICIU_B_REQ_IRQ] = events_i.countdown_expired | is_swirq;
  assign set_vec[NICIU_B_MEDIA_FAULT] = |(media_ctrl_status_i & NICIU_MEDIA_FAULT_SEL);
  assign set_vec[8] = 1'b0;
  assign set_vec[NICIU_B_DN_DONE] = events_i.download_done;
  assign set_vec[NICIU_B_UP_DONE] = events_i.upload_done;
  assign set_vec[NICIU_B_TX_STARVE] = events_i.transmit_starve;
  assign set_vec[NICIU_B_CMD_PEND] = 1'b0;
  assign set_vec[NICIU_B_ASTAT_FREE] = events_i.adapter_status_free;
  assign set_vec[NICIU_B_SYS_REQ] = events_i.system_request;
  assign set_vec[NICIU_B_AREQ] = events_i.adapter_request;

  wire [15:0] clr_vec = ack_mask
    | (fault_clear ? (16'h0001 << NICIU_B_HOST_FAULT) : 16'h0000)
    | (is_full_reset ? (16'h0001 << NICIU_B_MEDIA_FAULT) : 16'h0000)
    | (is_dn_reset ? (16'h0001 << NICIU_B_TX_STARVE) : 16'h0000);

  // Indication gates setting; latched events persist under mask changes
  wire [15:0] gated_set = set_vec & indication_mask & NICIU_LIVE_BITS;

  // Set wins over a clear in the same cycle; level bits follow their sources
  always_comb
  begin
    next_pending = (pending & ~clr_vec) | gated_set;
    next_pending[NICIU_B_UPD_WANTED] = events_i.upload_descriptor_wanted && !is_drop;
    next_pending[NICIU_B_RX_DONE] = events_i.receive_pending;
    next_pending[NICIU_B_CMD_PEND] = events_i.command_pending;
    next_pending[NICIU_B_SUMMARY] = 1'b0;
    next_pending = next_pending & NICIU_LIVE_BITS;
  end

  // ----------------------------------------
  // Visible status and interrupt
  // ----------------------------------------
  wire [15:0] visible = pending & indication_mask & NICIU_LIVE_BITS;
  // Cause after this cycle's clears, so a joint acknowledge drops the latch
  wire [15:0] kept_pending = pending & ~clr_vec;
  wire irq_cause = |(kept_pending & indication_mask & interrupt_mask & NICIU_IRQ_BITS);
  wire summary_ack = is_ack && cmd_arg[NICIU_B_SUMMARY];
  // Latch is set whenever the line is driven; line holds while latch is set
  assign next_summary = irq_cause || (summary && !summary_ack);
  wire [15:0] status_word = {visible[15:1], summary};

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pending <= NICIU_RESET_VAL;
      summary <= 1'b0;
    end
    else
    begin
      pending <= next_pending;
      summary <= next_summary;
    end
  end

  // Masks: only load commands write them, register port read-only
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      indication_mask <= NICIU_RESET_VAL;
      interrupt_mask <= NICIU_RESET_VAL;
    end
    else if (host_side_reset_bit_i)
    begin
      indication_mask <= NICIU_RESET_VAL;
      interrupt_mask <= NICIU_RESET_VAL;
    end
    else
    begin
      if (is_ld_ind)
        indication_mask <= {5'h00, cmd_arg};
      if (is_ld_int)
        interrupt_mask <= {5'h00, cmd_arg};
    end
  end

  // Interrupt line follows next summary so it rises with the latch
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pci_irq_o <= 1'b0;
    else
      pci_irq_o <= next_summary;
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [15:0] rd_sel;
  always_comb
  begin
    if (reg_addr_i == NICIU_ADDR_EVENT_STATUS)
      rd_sel = status_word;
    else if (reg_addr_i == NICIU_ADDR_INDICATION_MASK)
      rd_sel = indication_mask;
    else if (reg_addr_i == NICIU_ADDR_INTERRUPT_MASK)
      rd_sel = interrupt_mask;
    else
      rd_sel = 16'h0000;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_sel;
    else
      reg_rdata_o <= 16'h0000;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_MASKED_READS_ZERO: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == NICIU_ADDR_EVENT_STATUS) |=> ((reg_rdata_o[15:1] & ~$past(indication_mask[15:1])) == 15'h0000))
    else $error("masked status bit read as one");
  AST_IRQ_FROM_CAUSE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    irq_cause |=> pci_irq_o)
    else $error("enabled cause did not raise the line");
  AST_SUMMARY_HOLDS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (summary && !summary_ack) |=> summary)
    else $error("summary dropped without acknowledge");
  AST_LINE_MATCHES_SUMMARY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    pci_irq_o == summary)
    else $error("line and summary disagree");
  AST_MASK_KEEPS_PENDING: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (pending[NICIU_B_TX_DONE] && !ack_mask[NICIU_B_TX_DONE]) |=> pending[NICIU_B_TX_DONE])
    else $error("pending event lost without acknowledge");
  AST_CMD_PEND_NO_IRQ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!summary && (visible & interrupt_mask & NICIU_IRQ_BITS) == 16'h0000) |=> !pci_irq_o)
    else $error("line raised without cause");
  AST_DN_RESET_KEEPS_SUMMARY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_dn_reset && summary) |=> (summary && !pending[NICIU_B_TX_STARVE] || $past(set_vec[NICIU_B_TX_STARVE])))
    else $error("download reset misbehaved");
  AST_HOST_RESET_MASKS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    host_side_reset_bit_i |=> (indication_mask == 16'h0000 && interrupt_mask == 16'h0000))
    else $error("masks not cleared by host reset");
  AST_RESERVED_ZERO: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (pending[5] == 1'b0) && (pending[8] == 1'b0))
    else $error("reserved status bit set");

  // ----------------------------------------
  // Assertions: status and masks
  // ----------------------------------------
  AST_SET_NEEDS_INDICATION: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!pending[NICIU_B_TX_DONE] && !indication_mask[NICIU_B_TX_DONE])
    |=> !pending[NICIU_B_TX_DONE])
    else $error("status bit set while not indicated");

  AST_STATUS_READ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == NICIU_ADDR_EVENT_STATUS)
    |=> (reg_rdata_o == $past(status_word)))
    else $error("status read does not match status");

  AST_MASK_HIDES: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !indication_mask[NICIU_B_REQ_IRQ]
    |-> !visible[NICIU_B_REQ_IRQ])
    else $error("masked bit visible");

  AST_RESERVED_READ: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == NICIU_ADDR_EVENT_STATUS)
    |=> (reg_rdata_o[5] == 1'b0 && reg_rdata_o[8] == 1'b0))
    else $error("reserved bit read as one");

  // ----------------------------------------
  // Assertions: summary and line
  // ----------------------------------------
  AST_ENABLE_RAISES: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ((|(visible & interrupt_mask & NICIU_IRQ_BITS)) && clr_vec == 16'h0000)
    |=> summary)
    else $error("enabled pending cause did not raise summary");

  AST_SUMMARY_READS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (reg_rd_i && reg_addr_i == NICIU_ADDR_EVENT_STATUS)
    |=> (reg_rdata_o[NICIU_B_SUMMARY] == $past(summary)))
    else $error("summary bit read wrong");

  AST_CMD_PEND_IGNORED: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!summary && visible == 16'h1000)
    |=> !summary)
    else $error("command pending raised summary");

  // ----------------------------------------
  // Assertions: mask loading
  // ----------------------------------------
  AST_LOAD_INDICATION: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ld_ind && !host_side_reset_bit_i)
    |=> (indication_mask == {5'h00, $past(cmd_arg)}))
    else $error("indication mask not loaded");

  AST_LOAD_INTERRUPT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ld_int && !host_side_reset_bit_i)
    |=> (interrupt_mask == {5'h00, $past(cmd_arg)}))
    else $error("interrupt mask not loaded");

  AST_MASK_READONLY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (!is_ld_ind && !host_side_reset_bit_i)
    |=> $stable(indication_mask))
    else $error("indication mask changed without load");

  // ----------------------------------------
  // Assertions: fault and media bits
  // ----------------------------------------
  AST_FAULT_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (events_i.target_abort && indication_mask[NICIU_B_HOST_FAULT])
    |=> pending[NICIU_B_HOST_FAULT])
    else $error("host fault not set");

  AST_FAULT_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (fault_clear && !set_vec[NICIU_B_HOST_FAULT])
    |=> !pending[NICIU_B_HOST_FAULT])
    else $error("host fault not cleared");

  AST_FAULT_KEEPS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_full_reset && cmd_arg[NICIU_FULL_RESET_B3] && pending[NICIU_B_HOST_FAULT])
    |=> pending[NICIU_B_HOST_FAULT])
    else $error("host fault cleared with bit 3 set");

  AST_MEDIA_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (media_ctrl_status_i[14] && indication_mask[NICIU_B_MEDIA_FAULT])
    |=> pending[NICIU_B_MEDIA_FAULT])
    else $error("media fault not set");

  AST_MEDIA_STICKY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (pending[NICIU_B_MEDIA_FAULT] && !is_full_reset)
    |=> pending[NICIU_B_MEDIA_FAULT])
    else $error("media fault cleared without full reset");

  // ----------------------------------------
  // Assertions: transfer and request bits
  // ----------------------------------------
  AST_TX_DONE_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (events_i.transmit_done && indication_mask[NICIU_B_TX_DONE])
    |=> pending[NICIU_B_TX_DONE])
    else $error("transmit done not set");

  AST_UPD_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (events_i.upload_descriptor_wanted && !is_drop)
    |=> pending[NICIU_B_UPD_WANTED])
    else $error("descriptor wanted not shown");

  AST_UPD_DROP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    is_drop
    |=> !pending[NICIU_B_UPD_WANTED])
    else $error("descriptor wanted survived drop");

  AST_RX_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    1'b1
    |=> (pending[NICIU_B_RX_DONE] == $past(events_i.receive_pending)))
    else $error("receive done does not follow source");

  AST_REQ_IRQ_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_swirq && indication_mask[NICIU_B_REQ_IRQ])
    |=> pending[NICIU_B_REQ_IRQ])
    else $error("requested interrupt not set");

  AST_UP_DONE_SET: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (events_i.upload_done && indication_mask[NICIU_B_UP_DONE])
    |=> pending[NICIU_B_UP_DONE])
    else $error("upload done not set");

  // ----------------------------------------
  // Assertions: acknowledge and download reset
  // ----------------------------------------
  AST_JOINT_ACK: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ack && cmd_arg[NICIU_B_SUMMARY] && cmd_arg[NICIU_B_TX_DONE] && !events_i.transmit_done)
    |=> !pending[NICIU_B_TX_DONE])
    else $error("joint acknowledge left transmit done");

  AST_DN_RESET_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_dn_reset && !events_i.transmit_starve)
    |=> !pending[NICIU_B_TX_STARVE])
    else $error("download reset left starve bit");

  AST_REQ_IRQ_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ack && cmd_arg[NICIU_B_REQ_IRQ] && !set_vec[NICIU_B_REQ_IRQ])
    |=> !pending[NICIU_B_REQ_IRQ])
    else $error("requested interrupt not cleared");

  AST_DN_DONE_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ack && cmd_arg[NICIU_B_DN_DONE] && !events_i.download_done)
    |=> !pending[NICIU_B_DN_DONE])
    else $error("download done not cleared");

  AST_ACK_ONLY_NAMED: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    (is_ack && !cmd_arg[NICIU_B_REQ_IRQ] && pending[NICIU_B_REQ_IRQ])
    |=> pending[NICIU_B_REQ_IRQ])
    else $error("acknowledge cleared an unnamed bit");

endmodule

// *** tb/niciu_host_model.sv ***
// Host driver model: register port master and interrupt service
`timescale 1ns/1ns
module niciu_host_model
(
  // Clock
  input wire logic clk_sys_i,
  // Register port
  output logic [9:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [15:0] reg_rdata_i,
  // Interrupt line
  input wire logic pci_irq_i
);
  import niciu_pkg::*;
  initial
  begin
    reg_addr_o = 10'h000;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  task automatic wr16(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  task automatic rd16(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask
  task automatic cmd(input niciu_op_e op, input logic [10:0] arg);
    wr16(NICIU_ADDR_COMMAND, {op, arg});
  endtask
  // ----------------------------------------
  // Interrupt service: cause, sources, then summary
  // ----------------------------------------
  task automatic service(output logic [15:0] st);
    rd16(NICIU_ADDR_EVENT_STATUS, st);
    cmd(NICIU_OP_ACKNOWLEDGE, st[10:0] & NICIU_ACK_BITS[10:0] & 11'h7fe);
    cmd(NICIU_OP_ACKNOWLEDGE, 11'h001);
  endtask
endmodule

// *** tb/tb_niciu_top.sv ***
// Self-checking bench for the indication and interrupt unit
`timescale 1ns/1ns
module tb_niciu_top;
  import niciu_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic host_side_reset_bit_i = 1'b0;
  logic [9:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  niciu_events_s events = '0;
  logic [15:0] media_ctrl_status = 16'h0000;
  logic pci_irq;
  logic [15:0] v;
  int fail_count = 0;
  int compares = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  niciu_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .host_side_reset_bit_i(host_side_reset_bit_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .events_i(events), .media_ctrl_status_i(media_ctrl_status), .pci_irq_o(pci_irq));
  niciu_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata), .pci_irq_i(pci_irq));
  // ----------------------------------------
  // Checks and stimulus helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic st(input logic [15:0] exp_st, input logic exp_irq);
    host.rd16(NICIU_ADDR_EVENT_STATUS, v);
    check("event_status", v, exp_st);
    check("pci_irq", {15'h0000, pci_irq}, {15'h0000, exp_irq});
  endtask
  task automatic masks(input logic [15:0] exp_ind, input logic [15:0] exp_int);
    host.rd16(NICIU_ADDR_INDICATION_MASK, v);
    check("indication_mask", v & 16'h06de, exp_ind);
    host.rd16(NICIU_ADDR_INTERRUPT_MASK, v);
    check("interrupt_mask", v & 16'h06de, exp_int);
  endtask
  task automatic pulse(input niciu_events_s e);
    @(posedge clk_sys_i);
    events <= e;
    @(posedge clk_sys_i);
    events <= '0;
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    #(3000 * 100);
    fail_count++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    st(16'h0000, 1'b0);
    host.rd16(10'h3fc, v);
    check("unmapped", v, 16'h0000);
    pulse('{transmit_done: 1'b1, default: 1'b0});
    st(16'h0000, 1'b0);
    host.wr16(NICIU_ADDR_INDICATION_MASK, 16'hffff);
    host.wr16(NICIU_ADDR_INTERRUPT_MASK, 16'hffff);
    masks(16'h0000, 16'h0000);
    host.cmd(NICIU_OP_LOAD_INDICATION, 11'h6de);
    masks(16'h06de, 16'h0000);
    pulse('{transmit_done: 1'b1, default: 1'b0});
    st(16'h0004, 1'b0);
    host.cmd(NICIU_OP_LOAD_INTERRUPT, 11'h004);
    st(16'h0005, 1'b1);
    host.cmd(NICIU_OP_LOAD_INDICATION, 11'h6da);
    st(16'h0001, 1'b1);
    host.cmd(NICIU_OP_LOAD_INDICATION, 11'h6de);
    st(16'h0005, 1'b1);
    host.cmd(NICIU_OP_SOFTWARE_IRQ, 11'h000);
    st(16'h0045, 1'b1);
    host.cmd(NICIU_OP_ACKNOWLEDGE, 11'h005);
    st(16'h0040, 1'b0);
    host.cmd(NICIU_OP_LOAD_INTERRUPT, 11'h6de);
    st(16'h0041, 1'b1);
    host.service(v);
    st(16'h0000, 1'b0);
    pulse('{countdown_expired: 1'b1, default: 1'b0});
    st(16'h0041, 1'b1);
    host.service(v);
    pulse('{download_done: 1'b1, upload_done: 1'b1, default: 1'b0});
    st(16'h0601, 1'b1);
    host.cmd(NICIU_OP_ACKNOWLEDGE, 11'h201);
    st(16'h0401, 1'b1);
    host.service(v);
    st(16'h0000, 1'b0);
    pulse('{target_abort: 1'b1, default: 1'b0});
    host.cmd(NICIU_OP_FULL_RESET, 11'h008);
    st(16'h0003, 1'b1);
    host.cmd(NICIU_OP_FULL_RESET, 11'h000);
    st(16'h0001, 1'b1);
    pulse('{master_abort: 1'b1, false_starve: 1'b1, default: 1'b0});
    host.cmd(NICIU_OP_FULL_RESET, 11'h120);
    st(16'h0003, 1'b1);
    host.cmd(NICIU_OP_FULL_RESET, 11'h000);
    @(posedge clk_sys_i);
    media_ctrl_status <= 16'h4000;
    @(posedge clk_sys_i);
    media_ctrl_status <= 16'h0000;
    host.cmd(NICIU_OP_ACKNOWLEDGE, 11'h7fe);
    st(16'h0081, 1'b1);
    host.cmd(NICIU_OP_FULL_RESET, 11'h000);
    host.cmd(NICIU_OP_DOWNLOAD_RESET, 11'h000);
    st(16'h0001, 1'b1);
    host.cmd(NICIU_OP_ACKNOWLEDGE, 11'h001);
    st(16'h0000, 1'b0);
    @(posedge clk_sys_i);
    events <= '{receive_pending: 1'b1, default: 1'b0};
    @(posedge clk_sys_i);
    st(16'h0011, 1'b1);
    @(posedge clk_sys_i);
    events <= '0;
    host.cmd(NICIU_OP_RECEIVE_DROP, 11'h000);
    host.cmd(NICIU_OP_ACKNOWLEDGE, 11'h001);
    st(16'h0000, 1'b0);
    @(posedge clk_sys_i);
    host_side_reset_bit_i <= 1'b1;
    @(posedge clk_sys_i);
    host_side_reset_bit_i <= 1'b0;
    masks(16'h0000, 16'h0000);
    tally_and_finish();
  end
endmodule
